// ==== bench/board_model.sv ====
// Board side: pushbuttons pressed on request, reset outputs observed.
module board_model
  import supervisor_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic [1:0] supply_reset_n,
  input  wire logic [1:0] press,
  input  wire logic       main_press,
  input  wire logic       chain_en,
  input  wire logic       allow_short,
  output logic [1:0]      supply_button_n,
  output logic            main_button_n
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////
  localparam int MIN_CYC = (BUTTON_MIN_TICKS + 2) * TICK_CYCLES;
  logic [2:0] low = 3'h0;
  logic [2:0] req;
  int         held [3] = '{0, 0, 0};

  assign req = {main_press, press};

  // Presses stretch to the minimum unless allow_short.
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (req[i] || (low[i] && !allow_short && held[i] < MIN_CYC))
      begin
        low[i]  <= 1'b1;
        held[i] <= held[i] + 1;
      end
      else
      begin
        low[i]  <= 1'b0;
        held[i] <= 0;
      end
    end
  end

  assign supply_button_n[0] = ~low[0];
  assign supply_button_n[1] = ~low[1] & (~chain_en | supply_reset_n[0]);
  assign main_button_n = ~low[2];
endmodule // board_model

// ==== bench/supervisor_checker.sv ====
// Concurrent checks on the supervisor's reset and alarm outputs.
module supervisor_checker
  import supervisor_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       power_valid,
  input wire logic [1:0] supply_in_tol,
  input wire logic [1:0] supply_button_n,
  input wire logic       main_button_n,
  input wire logic [1:0] supply_reset_n,
  input wire logic [1:0] margin_code_25,
  input wire logic [1:0] margin_code_33,
  input wire logic       aux_alarm_a_n,
  input wire logic       aux_alarm_b_n,
  input wire logic       watchdog_expired_n,
  input wire logic       button_origin_flag_n
);
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Two ticks of slack cover the debounce and tick phase.
  localparam int MAIN_CYC = (BUTTON_MIN_TICKS + 2) * TICK_CYCLES;
  logic [15:0] main_cnt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || main_button_n)
      main_cnt <= 16'h0;
    else if (main_cnt != 16'hffff)
      main_cnt <= main_cnt + 16'h1;
  end

  a_tol_rst0:
    assert property (!supply_in_tol[0] |-> ##[0:1] !supply_reset_n[0])
    else $error("reset 0 high, supply out");
  a_tol_rst1:
    assert property (!supply_in_tol[1] |-> ##[0:1] !supply_reset_n[1])
    else $error("reset 1 high, supply out");
  a_rise_needs_tol:
    assert property ($rose(supply_reset_n[0]) |-> $past(supply_in_tol[0]))
    else $error("reset 0 rose, supply out");
  a_low_power_all:
    assert property (!power_valid |-> ##[0:2] (supply_reset_n == 2'h0
      && !aux_alarm_a_n && !aux_alarm_b_n))
    else $error("low power, output idle");
  a_button_hold:
    assert property (!supply_button_n[0] [*3] ##0 !supply_reset_n[0]
      |=> !supply_reset_n[0])
    else $error("reset 0 rose, button held");
  a_main_forces:
    assert property (main_cnt >= 16'(MAIN_CYC) && power_valid
      && supply_in_tol != 2'h0 |-> supply_reset_n == 2'h0
      && !aux_alarm_a_n && !aux_alarm_b_n)
    else $error("main press not forcing");
  a_reset_values:
    assert property ($rose(aresetn) |-> supply_reset_n == 2'h0
      && !aux_alarm_a_n && !aux_alarm_b_n && watchdog_expired_n
      && button_origin_flag_n)
    else $error("bad reset values");
  a_margin_frozen:
    assert property ($past(aresetn) && $past(aresetn, 2)
      |-> $stable(margin_code_25) && $stable(margin_code_33))
    else $error("margin code changed");

  c_release: cover property ($rose(supply_reset_n[0]));
  c_main: cover property (main_cnt >= 16'(MAIN_CYC) && power_valid);
  c_button: cover property (!supply_button_n[0] && !supply_reset_n[0]);
endmodule // supervisor_checker

bind dual_supply_reset_supervisor supervisor_checker u_checker (.aclk,
  .aresetn, .power_valid, .supply_in_tol, .supply_button_n, .main_button_n,
  .supply_reset_n, .margin_code_25, .margin_code_33, .aux_alarm_a_n,
  .aux_alarm_b_n, .watchdog_expired_n, .button_origin_flag_n);

// ==== bench/tb_top.sv ====
// Self-checking bench for the dual supply reset supervisor.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import supervisor_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  localparam int DS = 40;
  localparam int DM = 80;
  localparam int TC = TICK_CYCLES;
  typedef struct packed { logic [1:0] sel; logic [1:0] m; } row_t;
  row_t rows [4] = '{'{SEL_GND, MARGIN_10}, '{SEL_FLOAT, MARGIN_WIDE},
                     '{SEL_SUPPLY, MARGIN_5}, '{2'h3, MARGIN_WIDE}};
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, power_valid = 1'b1;
  logic [1:0]  supply_in_tol = 2'h0, margin_select_25 = 2'h0;
  logic [1:0]  margin_select_33 = 2'h0, delay_select_25 = 2'h0;
  logic [1:0]  delay_select_33 = 2'h0, watchdog_delay_select = 2'h0;
  logic [1:0]  press = 2'h0;
  logic        main_press = 1'b0, chain_en = 1'b0, allow_short = 1'b0;
  logic        aux_sense_a = 1'b1, aux_sense_b = 1'b1, watchdog_kick = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        aux_alarm_a_n, aux_alarm_b_n, watchdog_expired_n;
  logic        button_origin_flag_n, main_button_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp, supply_reset_n, supply_button_n;
  logic [1:0]  margin_code_25, margin_code_33;
  int          error_cnt = 0;
  int          compares = 0;

  dual_supply_reset_supervisor #(
    .DELAY_SHORT(DLY_W'(DS)), .DELAY_MID(DLY_W'(DM)), .DELAY_LONG(DLY_W'(120))
  ) dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .power_valid, .supply_in_tol, .margin_select_25, .margin_select_33,
    .delay_select_25, .delay_select_33, .watchdog_delay_select,
    .supply_button_n, .main_button_n, .aux_sense_a, .aux_sense_b,
    .watchdog_kick, .supply_reset_n, .margin_code_25, .margin_code_33,
    .aux_alarm_a_n, .aux_alarm_b_n, .watchdog_expired_n, .button_origin_flag_n
  );
  board_model u_model (.aclk, .supply_reset_n, .press, .main_press,
    .chain_en, .allow_short, .supply_button_n, .main_button_n);

  initial
  begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] got, exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic axi(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid  <= wr;
    s_axi_bready  <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready  <= !wr;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready)
           && !(s_axi_rvalid && s_axi_rready));
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    check(32'(wr ? s_axi_bresp : s_axi_rresp), 32'(er), "response");
  endtask

  task automatic measure(input int ch, input int ticks);
    int n;
    n = 0;
    while (supply_reset_n[ch] !== 1'b1 && n < (ticks + 2) * TC)
    begin
      @(posedge aclk);
      n++;
    end
    check(32'(n >= (ticks - 2) * TC && n < (ticks + 2) * TC), 32'h1, "delay");
  endtask

  initial
  begin
    foreach (rows[i])
    begin
      margin_select_25 <= rows[i].sel;
      margin_select_33 <= rows[i].sel;
      delay_select_25 <= rows[i].sel;
      delay_select_33 <= rows[i].sel;
      watchdog_delay_select <= rows[i].sel;
      do_reset();
      repeat (3) @(posedge aclk);
      check(32'(margin_code_25), 32'(rows[i].m), "margin a");
      check(32'(margin_code_33), 32'(rows[i].m), "margin b");
      axi(1'b0, CONFIG_ADDR, 32'h0, RESP_OKAY);
      check(32'(rd[3:0]), 32'({rows[i].m, rows[i].m}), "cfg");
      if (rows[i].sel != 2'h3)
        check(32'(rd[9:4]), 32'({3{rows[i].sel}}), "cfg delay");
    end
    margin_select_25 <= SEL_SUPPLY;
    margin_select_33 <= SEL_GND;
    delay_select_25 <= SEL_GND;
    delay_select_33 <= SEL_FLOAT;
    do_reset();
    repeat (2) @(posedge aclk);
    check(32'(supply_reset_n), 32'h0, "power-up");
    supply_in_tol <= 2'h3;
    measure(0, DS);
    check(32'(supply_reset_n[1]), 32'h0, "reset b early");
    measure(1, DM - DS);
    delay_select_25 <= SEL_SUPPLY;
    margin_select_25 <= SEL_GND;
    axi(1'b0, CONFIG_ADDR, 32'h0, RESP_OKAY);
    check(32'(rd[5:0]), 32'({SEL_GND, MARGIN_10, MARGIN_5}), "frozen");
    supply_in_tol <= 2'h2;
    repeat (3) @(posedge aclk);
    check(32'(supply_reset_n), 32'h2, "supply a out");
    supply_in_tol <= 2'h3;
    axi(1'b1, CTRL_ADDR, 32'h1, RESP_OKAY);
    axi(1'b0, CTRL_ADDR, 32'h0, RESP_OKAY);
    check(rd, 32'h1, "control");
    axi(1'b1, STATUS_ADDR, 32'h0, RESP_OKAY);
    axi(1'b1, 8'h0c, 32'h0, RESP_SLVERR);
    axi(1'b0, 8'h0c, 32'h0, RESP_SLVERR);
    check(rd, 32'h0, "unmapped");
    axi(1'b0, STATUS_ADDR, 32'h0, RESP_OKAY);
    check(32'(rd[8:0]), 32'h1fe, "status");
    axi(1'b1, CTRL_ADDR, 32'h0, RESP_OKAY);
    measure(0, DS);
    allow_short <= 1'b1;
    press <= 2'h1;
    repeat (10 * TC) @(posedge aclk);
    press <= 2'h0;
    repeat (4 * TC) @(posedge aclk);
    check(32'(supply_reset_n), 32'h3, "short press");
    allow_short <= 1'b0;
    chain_en <= 1'b1;
    press <= 2'h1;
    repeat (50 * TC) @(posedge aclk);
    check(32'(supply_reset_n), 32'h0, "press and chain");
    press <= 2'h0;
    measure(0, DS);
    measure(1, DM);
    chain_en <= 1'b0;
    allow_short <= 1'b1;
    main_press <= 1'b1;
    repeat (5 * TC) @(posedge aclk);
    main_press <= 1'b0;
    repeat (2 * TC) @(posedge aclk);
    check(32'(supply_reset_n), 32'h3, "main glitch");
    allow_short <= 1'b0;
    main_press <= 1'b1;
    repeat (30 * TC) @(posedge aclk);
    check(32'({supply_reset_n, aux_alarm_a_n, aux_alarm_b_n}), 32'h0,
          "main press");
    main_press <= 1'b0;
    measure(0, DS);
    check(32'({aux_alarm_a_n, aux_alarm_b_n}), 32'h3, "alarms");
    measure(1, DM - DS);
    power_valid <= 1'b0;
    repeat (3) @(posedge aclk);
    check(32'({supply_reset_n, aux_alarm_a_n}), 32'h0, "low power");
    print_verdict();
  end

  initial
  begin
    repeat (100000) @(posedge aclk);
    error_cnt++;
    $display("wrong value at %0t: timeout", $time);
    print_verdict();
  end
endmodule // tb_top

// ==== src/dual_supply_reset_supervisor.sv ====
// Dual supply reset supervisor with an AXI4-Lite status port.
// Contract
// - Out-of-tolerance supply asserts its own reset.
// - Recovery holds reset for selected delay.
// - Power-up releases each reset after delay.
// - 2.5V margin: supply 5, ground 10, float 15.
// - 3.3V margin: supply 5, ground 10, float 20.
// - Margin selections captured once after power-up.
// - Delay select: ground short, float mid, supply long.
// - Delay selections freeze once in tolerance.
// - Separate delay selects, plus watchdog delay.
// - Button low 20us starts one channel reset.
// - Held button keeps reset, then full delay.
// - Main button forces all resets and alarms.
// - Main press needs valid input, operating outputs.
// - Main press 20us; outputs hold after release.
// - Main button is debounced internally.
// - Watchdog and status builds replace some pins.
// - Low supplies keep every reset and alarm output active.
// - Status flag marks last reset from main button.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
module dual_supply_reset_supervisor
  import supervisor_pkg::*;
#(
  parameter variant_t         VARIANT = VARIANT_BASE,
  parameter logic [DLY_W-1:0] DELAY_SHORT = DLY_W'(DELAY_SHORT_US / TICK_US),
  parameter logic [DLY_W-1:0] DELAY_MID = DLY_W'(DELAY_MID_US / TICK_US),
  parameter logic [DLY_W-1:0] DELAY_LONG = DLY_W'(DELAY_LONG_US / TICK_US)
)
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  input  wire logic [supervisor_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [supervisor_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         power_valid,
  input  wire logic [1:0]                   supply_in_tol,
  input  wire logic [1:0]                   margin_select_25,
  input  wire logic [1:0]                   margin_select_33,
  input  wire logic [1:0]                   delay_select_25,
  input  wire logic [1:0]                   delay_select_33,
  input  wire logic [1:0]                   watchdog_delay_select,
  input  wire logic [1:0]                   supply_button_n,
  input  wire logic                         main_button_n,
  input  wire logic                         aux_sense_a,
  input  wire logic                         aux_sense_b,
  input  wire logic                         watchdog_kick,
  output logic [1:0]                        supply_reset_n,
  output logic [1:0]                        margin_code_25,
  output logic [1:0]                        margin_code_33,
  output logic                              aux_alarm_a_n,
  output logic                              aux_alarm_b_n,
  output logic                              watchdog_expired_n,
  output logic                              button_origin_flag_n
);

  logic [TICK_W-1:0] tick_count;
  logic              tick;
  logic              margin_done;
  logic              delay_frozen;
  logic [1:0]        dsel [3];
  logic [DLY_W-1:0]  delay_ticks [3];
  logic [1:0]        btn_s;
  logic [SHORT_W-1:0] btn_cnt [2];
  logic [1:0]        press;
  logic [1:0]        press_start;
  logic [1:0]        force_ch;
  logic              main_s;
  logic [SHORT_W-1:0] main_cnt;
  logic              main_hold;
  logic              main_start;
  logic              main_ok;
  logic [1:0]        sense;
  logic [1:0]        alarm_n;
  logic [SHORT_W-1:0] alarm_cnt [2];
  logic [1:0]        ctrl;
  logic              kick_q;
  logic [DLY_W-1:0]  wd_count;
  logic [SHORT_W-1:0] wd_pulse;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;

  function automatic logic [DLY_W-1:0] pick_delay(input logic [1:0] sel);
    unique case (sel)
      SEL_GND:    pick_delay = DELAY_SHORT;
      SEL_SUPPLY: pick_delay = DELAY_LONG;
      default:    pick_delay = DELAY_MID;
    endcase
  endfunction

  function automatic logic [1:0] pick_margin(input logic [1:0] sel);
    unique case (sel)
      SEL_SUPPLY: pick_margin = MARGIN_5;
      SEL_GND:    pick_margin = MARGIN_10;
      default:    pick_margin = MARGIN_WIDE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Free-running timebase; every timer counts its ticks.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_count <= '0;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      tick <= (tick_count == TICK_W'(TICK_CYCLES - 1));
      if (tick_count == TICK_W'(TICK_CYCLES - 1))
        tick_count <= '0;
      else
        tick_count <= tick_count + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Straps are caught after reset release.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      margin_done <= 1'b0;
      margin_code_25 <= MARGIN_5;
      margin_code_33 <= MARGIN_5;
    end
    else if (ce && !margin_done)
    begin
      margin_done <= 1'b1;
      margin_code_25 <= pick_margin(margin_select_25);
      margin_code_33 <= pick_margin(margin_select_33);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      delay_frozen <= 1'b0;
      dsel[0] <= SEL_GND;
      dsel[1] <= SEL_GND;
      dsel[2] <= SEL_GND;
    end
    else if (ce && !delay_frozen)
    begin
      delay_frozen <= power_valid && (|supply_in_tol);
      dsel[0] <= delay_select_25;
      dsel[1] <= delay_select_33;
      dsel[2] <= watchdog_delay_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-supply buttons and reset channels.
  assign main_ok = power_valid && ((|supply_in_tol) || aux_sense_a
                   || aux_sense_b);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      logic btn_raw;
      assign delay_ticks[gi] = pick_delay(dsel[gi]);
      assign btn_raw = (VARIANT == VARIANT_STATUS && gi == 1) ? 1'b1
                       : supply_button_n[gi];
      assign press_start[gi] = tick && !btn_s[gi] && supply_reset_n[gi]
          && btn_cnt[gi] == SHORT_W'(BUTTON_MIN_TICKS - 1);
      assign force_ch[gi] = press[gi] || main_hold || ctrl[gi]
                            || !power_valid;

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          btn_s[gi] <= 1'b1;
          btn_cnt[gi] <= '0;
          press[gi] <= 1'b0;
        end
        else if (ce)
        begin
          btn_s[gi] <= btn_raw;
          if (btn_s[gi])
            btn_cnt[gi] <= '0;
          else if (tick && btn_cnt[gi] != SHORT_W'(BUTTON_MIN_TICKS))
            btn_cnt[gi] <= btn_cnt[gi] + 1'b1;
          if (btn_s[gi])
            press[gi] <= 1'b0;
          else if (press_start[gi])
            press[gi] <= 1'b1;
        end
      end

      reset_channel u_channel (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .ce           (ce),
        .tick         (tick),
        .in_tol       (supply_in_tol[gi]),
        .force_active (force_ch[gi]),
        .delay_ticks  (delay_ticks[gi]),
        .reset_n      (supply_reset_n[gi])
      );
    end
  endgenerate

  assign delay_ticks[2] = pick_delay(dsel[2]);

  ////////////////////////////////////////////////////////////////////////////
  // Main button: a press counts only after it has stayed low 20 us.
  assign main_start = tick && !main_s && !main_hold && main_ok
      && main_cnt == SHORT_W'(BUTTON_MIN_TICKS - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_s <= 1'b1;
      main_cnt <= '0;
      main_hold <= 1'b0;
    end
    else if (ce)
    begin
      main_s <= main_button_n || VARIANT == VARIANT_WATCHDOG;
      if (main_s)
        main_cnt <= '0;
      else if (tick && main_cnt != SHORT_W'(BUTTON_MIN_TICKS))
        main_cnt <= main_cnt + 1'b1;
      if (main_s)
        main_hold <= 1'b0;
      else if (main_start)
        main_hold <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarms stay low for a minimum time after their cause goes away.
  assign sense = {aux_sense_b, aux_sense_a};

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_alarm
      logic cause;
      assign cause = !sense[gi] || main_hold || !power_valid;

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          alarm_cnt[gi] <= '0;
          alarm_n[gi] <= 1'b0;
        end
        else if (ce)
        begin
          if (cause)
            alarm_cnt[gi] <= SHORT_W'(ALARM_HOLD_TICKS);
          else if (tick && alarm_cnt[gi] != '0)
            alarm_cnt[gi] <= alarm_cnt[gi] - 1'b1;
          alarm_n[gi] <= !cause && alarm_cnt[gi] == '0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aux_alarm_a_n <= 1'b0;
      aux_alarm_b_n <= 1'b0;
    end
    else if (ce)
    begin
      aux_alarm_a_n <= alarm_n[0];
      aux_alarm_b_n <= alarm_n[1] || VARIANT == VARIANT_WATCHDOG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Origin flag: a main press sets it low and wins over a clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      button_origin_flag_n <= 1'b1;
    else if (ce && VARIANT == VARIANT_STATUS)
    begin
      if (main_start)
        button_origin_flag_n <= 1'b0;
      else if ((|press_start) || (|(~supply_in_tol)) || (|ctrl))
        button_origin_flag_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog timer, only in the watchdog build.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      kick_q <= 1'b0;
      wd_count <= '0;
      wd_pulse <= '0;
      watchdog_expired_n <= 1'b1;
    end
    else if (ce)
    begin
      kick_q <= watchdog_kick;
      if (VARIANT != VARIANT_WATCHDOG || !(|supply_reset_n)
          || kick_q != watchdog_kick)
        wd_count <= '0;
      else if (wd_count >= delay_ticks[2])
        wd_count <= '0;
      else if (tick)
        wd_count <= wd_count + 1'b1;
      if (VARIANT == VARIANT_WATCHDOG && wd_count >= delay_ticks[2])
        wd_pulse <= SHORT_W'(WD_PULSE_TICKS);
      else if (tick && wd_pulse != '0)
        wd_pulse <= wd_pulse - 1'b1;
      watchdog_expired_n <= wd_pulse == '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path; address and data may arrive in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl <= CTRL_RESET;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_held <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (!aw_held && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (!w_held && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (aw_held && w_held)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        if ({awaddr_q[ADDR_W-1:2], 2'b00} == CTRL_ADDR)
        begin
          if (wstrb_q[0])
            ctrl <= wdata_q[1:0];
        end
        else if ({awaddr_q[ADDR_W-1:2], 2'b00} != STATUS_ADDR
                 && {awaddr_q[ADDR_W-1:2], 2'b00} != CONFIG_ADDR)
          s_axi_bresp <= RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path.
  always_comb
  begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
      CTRL_ADDR:   next_rdata = {30'h0, ctrl};
      STATUS_ADDR: next_rdata = {24'h0, power_valid, supply_in_tol,
                                 button_origin_flag_n, watchdog_expired_n,
                                 aux_alarm_b_n, aux_alarm_a_n,
                                 supply_reset_n[1]} << 1
                                | {31'h0, supply_reset_n[0]};
      CONFIG_ADDR: next_rdata = {22'h0, dsel[2], dsel[1], dsel[0],
                                 margin_code_33, margin_code_25};
      default:     next_rresp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

endmodule // dual_supply_reset_supervisor

// ==== src/reset_channel.sv ====
// One supply reset channel: hold while forced, then time the release.
module reset_channel
  import supervisor_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             tick,
  input  wire logic             in_tol,
  input  wire logic             force_active,
  input  wire logic [DLY_W-1:0] delay_ticks,
  output logic                  reset_n
);

  logic [DLY_W-1:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // Any out-of-tolerance or forced cycle restarts the full delay.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= '0;
    else if (ce)
    begin
      if (!in_tol || force_active)
        count <= '0;
      else if (tick && count < delay_ticks)
        count <= count + 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reset_n <= 1'b0;
    else if (ce)
    begin
      if (!in_tol || force_active)
        reset_n <= 1'b0;
      else if (count >= delay_ticks)
        reset_n <= 1'b1;
    end
  end

endmodule // reset_channel

// ==== src/supervisor_pkg.sv ====
// Shared constants and types for the dual supply reset supervisor.
package supervisor_pkg;

  localparam int CLK_NS = 5;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int TICK_W = 8;
  localparam int TICK_US = 1;

  localparam int DLY_W = 21;
  localparam int DELAY_SHORT_US = 16000;
  localparam int DELAY_MID_US = 160000;
  localparam int DELAY_LONG_US = 1600000;

  localparam int BUTTON_MIN_US = 20;
  localparam int ALARM_HOLD_US = 10;
  localparam int WD_PULSE_US = 100;
  localparam int BUTTON_MIN_TICKS = (BUTTON_MIN_US + TICK_US - 1) / TICK_US;
  localparam int ALARM_HOLD_TICKS = (ALARM_HOLD_US + TICK_US - 1) / TICK_US;
  localparam int WD_PULSE_TICKS = (WD_PULSE_US + TICK_US - 1) / TICK_US;
  localparam int SHORT_W = 8;

  localparam logic [1:0] SEL_GND = 2'h0;
  localparam logic [1:0] SEL_FLOAT = 2'h1;
  localparam logic [1:0] SEL_SUPPLY = 2'h2;

  localparam logic [1:0] MARGIN_5 = 2'h0;
  localparam logic [1:0] MARGIN_10 = 2'h1;
  localparam logic [1:0] MARGIN_WIDE = 2'h2;

  typedef enum logic [1:0] {
    VARIANT_BASE     = 2'b00,
    VARIANT_WATCHDOG = 2'b01,
    VARIANT_STATUS   = 2'b10
  } variant_t;

  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CONFIG_ADDR = 8'h08;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
